// [logic/aoi_audio_out.v]
// Audio output control: flags, interrupt, control, timestamp, powerdown and prefetch logic.
// Assumes one processor clock, a synchronous active-low reset and an AXI4-Lite master.
// The memory highway answers fetch requests with 16 words on fill_valid/fill_ready.
`include "aoi_defs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Unit drives one dedicated interrupt line, source number 12.
// - Interrupt active while any flag is set together with its enable.
// - Flags stay set until software clears them; never clear on their own.
// - Writing the unit reset field returns the audio output logic to reset.
// - Transmit enable resets to 0; at 1 unit transmits and fetches samples.
// - Keep-awake resets cleared; when set unit keeps working, interrupts wake processor.
// - Four interrupt enables default 0; 1 lets the flag request the interrupt.
// - Clear fields clear flag when written 1; 0 does nothing; read 0.
// - Read-only timestamp holds cycle count when last buffer sample left.
// - Internal counter loads processor cycle count, then tracks its low 32 bits.
// - Chip powerdown powers unit down unless keep-awake; then DMA continues, wakes.
// - Timestamp counter keeps counting through every powerdown.
// - Block powerdown bit powers the unit down on its own.
// - Powered down, serial outputs hold still, converter clock toggles, resume in place.
// - Samples prefetched into a 64-byte buffer feeding a one-sample holding register.
// - Buffer dry and holding register used when sample due sets bandwidth error.
// - During bandwidth error last sample is resent until fresh data arrives.
// - Bandwidth error stays set after refill until its clear write.
// - No new buffer in time sets starved flag, repeats sample; buffer clears keep it.
// - Buffer clear write withdraws the buffer interrupt at the next clock edge.
// - Exhausted buffer sets its drained flag and output continues from the other.
module aoi_audio_out #(
  parameter WORDS = `AOI_PREFETCH_WORDS,
  parameter BIT_HALF = `AOI_BIT_HALF_CYCLES,
  parameter OSC_HALF = `AOI_OSC_HALF_CYCLES
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register slave.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Processor side.
  output wire irq_source_twelve,
  output wire cpu_wake,
  input wire [31:0] cpu_cycle_count,
  input wire cycle_count_config_bit,
  input wire chip_powerdown,
  input wire block_powerdown,
  // Memory highway.
  output wire fetch_req,
  output reg [31:0] fetch_addr,
  input wire fill_valid,
  input wire [31:0] fill_data,
  output wire fill_ready,
  // Converter pins.
  output wire serial_bit_clock,
  output reg serial_data_outputs,
  output reg word_select,
  output reg converter_oversample_clock
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.
  reg aw_have_q, w_have_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg soft_rst_q;
  wire rst = ~aresetn | soft_rst_q;
  wire do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits = w_data_q & mask;
  wire wr_ctrl = do_wr & (aw_addr_q == `AOI_OFS_CTRL);

  // Status and timestamp are read-only, and every address outside the map is
  // refused too; a refused write still gets its response so the master never hangs.
  reg wr_bad;
  always @* begin
    case (aw_addr_q)
      `AOI_OFS_CTRL: wr_bad = 1'b0;
      `AOI_OFS_BASE1: wr_bad = 1'b0;
      `AOI_OFS_BASE2: wr_bad = 1'b0;
      `AOI_OFS_SIZE: wr_bad = 1'b0;
      default: wr_bad = 1'b1;
    endcase
  end

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // The bus slave is held by the external reset only, so a unit reset written over
  // the bus still gets its write response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AOI_RESP_OKAY;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctrl & wbits[`AOI_CTL_UNIT_RESET];
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? `AOI_RESP_SLVERR : `AOI_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and buffer registers.
  reg [7:0] ctrl_q;
  reg [31:0] base1_q, base2_q, size_q;
  wire tx_on = ctrl_q[`AOI_CTL_TX_ON];
  wire keep_awake = ctrl_q[`AOI_CTL_KEEP_AWAKE];
  wire [3:0] irq_en = ctrl_q[`AOI_CTL_EN_STARVED:`AOI_CTL_EN_FIRST];

  always @(posedge aclk) begin
    if (rst) begin
      ctrl_q <= `AOI_CTRL_RST;
      base1_q <= `AOI_WORD_RST;
      base2_q <= `AOI_WORD_RST;
      size_q <= `AOI_WORD_RST;
    end else if (do_wr) begin
      case (aw_addr_q)
        `AOI_OFS_CTRL: ctrl_q <= (ctrl_q & ~mask[7:0]) | wbits[7:0];
        `AOI_OFS_BASE1: base1_q <= (base1_q & ~mask) | wbits;
        `AOI_OFS_BASE2: base2_q <= (base2_q & ~mask) | wbits;
        `AOI_OFS_SIZE: size_q <= (size_q & ~mask) | wbits;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Clear pulses from the control word; they are never stored, so they read 0.
  wire clr_first = wr_ctrl & wbits[`AOI_CTL_CLR_FIRST];
  wire clr_second = wr_ctrl & wbits[`AOI_CTL_CLR_SECOND];
  wire clr_bw = wr_ctrl & wbits[`AOI_CTL_CLR_BW];
  wire clr_starved = wr_ctrl & wbits[`AOI_CTL_CLR_STARVED];

  ////////////////////////////////////////////////////////////////////////////////
  // Powerdown.
  wire powered_down = block_powerdown | (chip_powerdown & ~keep_awake);

  ////////////////////////////////////////////////////////////////////////////////
  // Timestamp counter, outside the unit reset so it stays in step with the processor.
  reg [31:0] ts_cnt_q, tstamp_q;
  always @(posedge aclk) begin
    if (!aresetn || !cycle_count_config_bit) begin
      // The processor count moves on at this same edge, so the load is one ahead
      // to keep both counters equal from the next cycle on.
      ts_cnt_q <= cpu_cycle_count + 32'h00000001;
    end else begin
      ts_cnt_q <= ts_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock toggles regardless of powerdown.
  reg [7:0] osc_cnt_q;
  always @(posedge aclk) begin
    if (rst) begin
      osc_cnt_q <= 8'h00;
      converter_oversample_clock <= 1'b0;
    end else if (osc_cnt_q == OSC_HALF[7:0] - 8'h01) begin
      osc_cnt_q <= 8'h00;
      converter_oversample_clock <= ~converter_oversample_clock;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prefetch buffer of 64 bytes.
  reg [31:0] pf_mem [0:WORDS-1];
  reg [3:0] pf_wp_q, pf_rp_q;
  reg [4:0] pf_cnt_q;
  reg fetching_q;
  reg [4:0] fill_left_q;
  reg [31:0] fetch_ofs_q;
  wire pop;
  wire pf_empty = (pf_cnt_q == 5'd0);
  wire push = fill_valid & fill_ready;

  // A whole burst is requested only into an empty buffer; the buffer then always has room.
  // The trade-off is one burst of latency per refill instead of a fill-level watermark.
  assign fill_ready = fetching_q;
  assign fetch_req = tx_on & ~powered_down & pf_empty & ~fetching_q;

  always @(posedge aclk) begin
    if (push) begin
      pf_mem[pf_wp_q] <= fill_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial sequencer with holding register.
  reg [7:0] bit_cnt_q;
  reg [4:0] bit_idx_q;
  reg sck_q;
  reg [31:0] hold_q;
  reg hold_full_q;
  reg first_active_q;
  reg [31:0] sent_q;
  reg [3:0] flags_q; // {starved, bw, second, first}
  // Nothing here restarts the frame on wake-up; an external converter may lose
  // word alignment across a long powerdown, which software is expected to avoid.
  wire run = tx_on & ~powered_down;
  wire half_tick = run & (bit_cnt_q == BIT_HALF[7:0] - 8'h01);
  wire fall = half_tick & sck_q;
  wire frame_end = fall & (bit_idx_q == 5'd31);
  wire other_drained = first_active_q ? flags_q[1] : flags_q[0];
  wire buf_done = frame_end & (sent_q + 32'h00000001 >= size_q) & hold_full_q;
  wire starve_now = frame_end & other_drained & (sent_q >= size_q);
  assign pop = frame_end & ~pf_empty & ~starve_now;

  always @(posedge aclk) begin
    if (rst) begin
      bit_cnt_q <= 8'h00;
      bit_idx_q <= 5'd0;
      sck_q <= 1'b0;
      serial_data_outputs <= 1'b0;
      word_select <= 1'b0;
    end else if (run) begin
      // Counters freeze while powered down, so output resumes exactly where it stopped.
      bit_cnt_q <= half_tick ? 8'h00 : bit_cnt_q + 8'h01;
      if (half_tick) begin
        sck_q <= ~sck_q;
      end
      if (fall) begin
        bit_idx_q <= bit_idx_q + 5'd1;
        serial_data_outputs <= hold_q[5'd31 - bit_idx_q];
        word_select <= bit_idx_q[4];
      end
    end
  end

  assign serial_bit_clock = sck_q ^ ctrl_q[`AOI_CTL_POLARITY];

  always @(posedge aclk) begin
    if (rst) begin
      pf_wp_q <= 4'h0;
      pf_rp_q <= 4'h0;
      pf_cnt_q <= 5'd0;
      fetching_q <= 1'b0;
      fill_left_q <= 5'd0;
      fetch_ofs_q <= 32'h00000000;
      fetch_addr <= 32'h00000000;
      hold_q <= 32'h00000000;
      hold_full_q <= 1'b0;
      first_active_q <= 1'b1;
      sent_q <= 32'h00000000;
      tstamp_q <= 32'h00000000;
    end else begin
      if (fetch_req) begin
        fetching_q <= 1'b1;
        fill_left_q <= WORDS[4:0];
        fetch_addr <= (first_active_q ? base1_q : base2_q) + fetch_ofs_q;
        fetch_ofs_q <= fetch_ofs_q + `AOI_PREFETCH_BYTES;
      end
      if (push) begin
        pf_wp_q <= pf_wp_q + 4'h1;
        fill_left_q <= fill_left_q - 5'd1;
        if (fill_left_q == 5'd1) begin
          fetching_q <= 1'b0;
        end
      end
      pf_cnt_q <= pf_cnt_q + {4'h0, push} - {4'h0, pop};
      if (pop) begin
        hold_q <= pf_mem[pf_rp_q];
        hold_full_q <= 1'b1;
        pf_rp_q <= pf_rp_q + 4'h1;
        sent_q <= sent_q + 32'h00000001;
      end else if (frame_end) begin
        hold_full_q <= 1'b0;
      end
      if (buf_done & ~other_drained) begin
        first_active_q <= ~first_active_q;
        sent_q <= 32'h00000000;
        fetch_ofs_q <= 32'h00000000;
        tstamp_q <= ts_cnt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Condition flags: a hardware set wins over a clear in the same cycle.
  wire [3:0] set_f;
  wire [3:0] clr_f = {clr_starved, clr_bw, clr_second, clr_first};
  assign set_f[0] = buf_done & ~other_drained & first_active_q;
  assign set_f[1] = buf_done & ~other_drained & ~first_active_q;
  assign set_f[2] = frame_end & pf_empty & ~starve_now;
  assign set_f[3] = starve_now;

  always @(posedge aclk) begin
    if (rst) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= set_f | (flags_q & ~clr_f);
    end
  end

  assign irq_source_twelve = |(flags_q & irq_en);
  assign cpu_wake = chip_powerdown & keep_awake & irq_source_twelve;

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AOI_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AOI_RESP_OKAY;
      case (s_axi_araddr)
        `AOI_OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
        `AOI_OFS_STAT: s_axi_rdata <= {26'h0000000, powered_down, first_active_q, flags_q};
        `AOI_OFS_BASE1: s_axi_rdata <= base1_q;
        `AOI_OFS_BASE2: s_axi_rdata <= base2_q;
        `AOI_OFS_SIZE: s_axi_rdata <= size_q;
        `AOI_OFS_TSTAMP: s_axi_rdata <= tstamp_q;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AOI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [logic/aoi_defs.vh]
// Constants of the audio output control block: register map, fields, reset values, timing.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz processor clock.
`ifndef AOI_DEFS_VH
`define AOI_DEFS_VH

// Register byte offsets.
`define AOI_OFS_CTRL 8'h00
`define AOI_OFS_STAT 8'h04
`define AOI_OFS_BASE1 8'h08
`define AOI_OFS_BASE2 8'h0C
`define AOI_OFS_SIZE 8'h10
`define AOI_OFS_TSTAMP 8'h14

// Control register fields.
`define AOI_CTL_TX_ON 0
`define AOI_CTL_KEEP_AWAKE 1
`define AOI_CTL_POLARITY 2
`define AOI_CTL_EN_FIRST 4
`define AOI_CTL_EN_SECOND 5
`define AOI_CTL_EN_BW 6
`define AOI_CTL_EN_STARVED 7
`define AOI_CTL_CLR_FIRST 8
`define AOI_CTL_CLR_SECOND 9
`define AOI_CTL_CLR_BW 10
`define AOI_CTL_CLR_STARVED 11
`define AOI_CTL_UNIT_RESET 31

// Status register fields.
`define AOI_ST_FIRST 0
`define AOI_ST_SECOND 1
`define AOI_ST_BW 2
`define AOI_ST_STARVED 3
`define AOI_ST_FIRST_ACTIVE 4
`define AOI_ST_POWERED_DOWN 5

// Reset values.
`define AOI_CTRL_RST 8'h00
`define AOI_WORD_RST 32'h00000000

// Bus responses.
`define AOI_RESP_OKAY 2'b00
`define AOI_RESP_SLVERR 2'b10

// Prefetch buffer: 64 bytes of 32-bit words.
`define AOI_PREFETCH_BYTES 64
`define AOI_PREFETCH_WORDS 16

// Serial timing: half period of the bit clock and of the converter clock, in clock cycles.
`define AOI_BIT_HALF_CYCLES 4
`define AOI_OSC_HALF_CYCLES 1

// Interrupt source number of the unit's request line.
`define AOI_IRQ_SOURCE 12

`endif

// [verification/aoi_chk_assertions.sv]
// Port checker for the audio output control block.
// Assumes the single aclk domain and the synchronous active-low aresetn.
`default_nettype none
module aoi_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports.
  input wire logic irq_source_twelve,
  input wire logic cpu_wake,
  input wire logic chip_powerdown,
  input wire logic block_powerdown,
  input wire logic fetch_req,
  input wire logic fill_ready,
  input wire logic s_axi_bvalid,
  input wire logic serial_bit_clock,
  input wire logic serial_data_outputs,
  input wire logic word_select,
  input wire logic converter_oversample_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_quiet; $rose(aresetn) |-> !irq_source_twelve; endproperty
  a_quiet: assert property (p_quiet) else $error("irq high after reset");
  property p_wake; cpu_wake |-> chip_powerdown && irq_source_twelve; endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_burst; fetch_req |=> fill_ready && !fetch_req; endproperty
  a_burst: assert property (p_burst) else $error("fetch not followed by burst");
  property p_nofetch; block_powerdown [*3] |-> !fetch_req; endproperty
  a_nofetch: assert property (p_nofetch) else $error("fetch while down");
  property p_frozen; block_powerdown [*3] |=> $stable(serial_bit_clock)
    && $stable(serial_data_outputs) && $stable(word_select); endproperty
  a_frozen: assert property (p_frozen) else $error("pins moved while down");
  property p_osc; block_powerdown && $past(aresetn) |=>
    converter_oversample_clock != $past(converter_oversample_clock); endproperty
  a_osc: assert property (p_osc) else $error("converter clock stopped");
  property p_sticky; $fell(irq_source_twelve) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq fell without write");
  property p_awake; chip_powerdown && irq_source_twelve && !cpu_wake |-> ##1 !cpu_wake
    || !irq_source_twelve || !chip_powerdown || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_awake: assert property (p_awake) else $error("wake flipped on its own");
endmodule
bind aoi_audio_out aoi_chk u_chk (.aclk, .aresetn, .irq_source_twelve, .cpu_wake,
  .chip_powerdown, .block_powerdown, .fetch_req, .fill_ready, .s_axi_bvalid,
  .serial_bit_clock, .serial_data_outputs, .word_select, .converter_oversample_clock);
`default_nettype wire

// [verification/aoi_highway_model.sv]
// Memory highway model: answers each fetch with 16 words, stalls on request.
// Assumes the design's aclk and that fill_ready qualifies every word.
`default_nettype none
module aoi_highway_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Highway.
  input wire logic fetch_req,
  input wire logic fill_ready,
  input wire logic stall,
  output logic fill_valid,
  output logic [31:0] fill_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left_q;
  logic [31:0] word_q;
  // Prompt answer when not stalled keeps latency within the sample interval.
  always @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= 5'h00;
      word_q <= 32'hA5C30000;
      fill_valid <= 1'b0;
      fill_data <= 32'h5A3CFFFF;
    end else if (fill_valid && fill_ready) begin
      left_q <= left_q - 5'h01;
      word_q <= word_q + 32'h00000001;
      fill_valid <= 1'b0;
      fill_data <= ~fill_data;
    end else if (!fill_valid) begin
      if (fetch_req && left_q == 5'h00) left_q <= 5'h10;
      fill_valid <= left_q != 5'h00 && !stall;
      // A released bus alternates between the last word and its complement.
      fill_data <= (left_q != 5'h00 && !stall) ? word_q : ~fill_data;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_audio_out_irq_power_control.sv]
// Testbench of the audio output control block over its AXI4-Lite register port.
// Assumes the design, its constants header, the checker and the highway model.
`include "aoi_defs.vh"
`default_nettype none
module tb_audio_out_irq_power_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cycle_count_config_bit = 1;
  logic chip_powerdown = 0, block_powerdown = 0, stall = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, cpu_cycle_count = 0, rdat;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic irq_source_twelve, cpu_wake, fetch_req, fill_valid, fill_ready;
  wire logic serial_bit_clock, serial_data_outputs, word_select, converter_oversample_clock;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, fetch_addr, fill_data;
  int miscompares = 0, samples_checked = 0;
  aoi_audio_out dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_source_twelve, .cpu_wake,
    .cpu_cycle_count, .cycle_count_config_bit, .chip_powerdown, .block_powerdown,
    .fetch_req, .fetch_addr, .fill_valid, .fill_data, .fill_ready, .serial_bit_clock,
    .serial_data_outputs, .word_select, .converter_oversample_clock);
  aoi_highway_model u_hw (.aclk, .aresetn, .fetch_req, .fill_ready, .stall, .fill_valid,
    .fill_data);
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) cpu_cycle_count <= cpu_cycle_count + 32'h00000001;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1) begin
      // Handshakes are judged mid-cycle, where the values that the next edge samples stand.
      @(negedge aclk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      r_hs = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(rdat & m, e);
  endtask
  task automatic wait_irq(input int limit);
    for (int n = 0; n < limit && irq_source_twelve !== 1'b1; n++) @(posedge aclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    miscompares++;
    give_verdict();
  end
  // Polarity is never written while transmit is on.
  // Powerdown with transmit on is kept on purpose, to see the pins freeze.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`AOI_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(`AOI_OFS_STAT, 32'h3F, 32'h10);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    check(resp, `AOI_RESP_SLVERR);
    wr(`AOI_OFS_TSTAMP, 32'h1234ABCD);
    check(resp, `AOI_RESP_SLVERR);
    wr(`AOI_OFS_BASE1, 32'h1000);
    wr(`AOI_OFS_BASE2, 32'h2000);
    wr(`AOI_OFS_SIZE, 32'h1);
    wr(`AOI_OFS_CTRL, 32'h11);
    wait_irq(3000);
    #1 check(irq_source_twelve, 1'b1);
    check(fetch_addr, 32'h00001000);
    rd_chk(`AOI_OFS_STAT, 32'h1, 32'h1);
    wr(`AOI_OFS_CTRL, 32'h111);
    #1 check(irq_source_twelve, 1'b0);
    rd_chk(`AOI_OFS_CTRL, 32'hFFFFFFFF, 32'h11);
    repeat (1200) @(posedge aclk);
    rd_chk(`AOI_OFS_STAT, 32'h8, 32'h8);
    rd(`AOI_OFS_TSTAMP);
    check(rdat != 0 && rdat < cpu_cycle_count, 1'b1);
    wr(`AOI_OFS_CTRL, 32'h81);
    #1 check(irq_source_twelve, 1'b1);
    @(posedge aclk) chip_powerdown <= 1'b1;
    wr(`AOI_OFS_CTRL, 32'h83);
    #1 check(cpu_wake, 1'b1);
    rd_chk(`AOI_OFS_STAT, 32'h20, 32'h0);
    wr(`AOI_OFS_CTRL, 32'h81);
    #1 check(cpu_wake, 1'b0);
    rd_chk(`AOI_OFS_STAT, 32'h20, 32'h20);
    chip_powerdown <= 1'b0;
    block_powerdown <= 1'b1;
    repeat (300) @(posedge aclk);
    rd_chk(`AOI_OFS_STAT, 32'h28, 32'h28);
    block_powerdown <= 1'b0;
    wr(`AOI_OFS_CTRL, 32'h800);
    rd_chk(`AOI_OFS_STAT, 32'h8, 32'h0);
    wr(`AOI_OFS_CTRL, 32'h80000000);
    rd_chk(`AOI_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(`AOI_OFS_STAT, 32'h3F, 32'h10);
    stall <= 1'b1;
    wr(`AOI_OFS_BASE1, 32'h4000);
    wr(`AOI_OFS_BASE2, 32'h8000);
    wr(`AOI_OFS_SIZE, 32'h40);
    wr(`AOI_OFS_CTRL, 32'h41);
    wait_irq(3000);
    rd_chk(`AOI_OFS_STAT, 32'h4, 32'h4);
    check(fetch_addr, 32'h00004000);
    stall <= 1'b0;
    repeat (600) @(posedge aclk);
    rd_chk(`AOI_OFS_STAT, 32'h4, 32'h4);
    wr(`AOI_OFS_CTRL, 32'h441);
    rd_chk(`AOI_OFS_STAT, 32'h4, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
